// ### shared/adc_pkg.sv
// Constants, types and coding layout for the dual-channel converter control
package adc_pkg;

	// Result coding: natural binary, 14-bit variant
	localparam int RESULT_BITS      = 14;
	localparam int LSB_DIVISOR_14   = 16384;
	localparam int LSB_DIVISOR_12   = 4096;
	localparam int PAIR_BITS        = 2 * RESULT_BITS;

	// Analog inputs arrive as unsigned fractions; span (2.5 V) equals 2**SPAN_BITS units
	localparam int SPAN_MILLIVOLTS  = 2500;
	localparam int INPUT_BITS       = 21;
	localparam int SPAN_BITS        = 20;
	localparam logic signed [INPUT_BITS:0] SPAN_UNITS = 22'sh10_0000;
	localparam logic [RESULT_BITS-1:0] CODE_ALL_ONES  = 14'h3fff;
	localparam logic [RESULT_BITS-1:0] CODE_ALL_ZEROS = 14'h0000;

	// Serial frame, counted in serial clock rising edges after the strobe
	localparam logic [5:0] FIRST_DATA_EDGE = 6'h03;
	localparam logic [5:0] WORD0_LAST_EDGE = 6'h10;
	localparam logic [5:0] GAP_LAST_EDGE   = 6'h12;
	localparam logic [5:0] FRAME_EDGES     = 6'h20;
	localparam logic [5:0] EDGE_COUNT_RESET = 6'h00;

	// Power-down strobe counts
	localparam logic [2:0] NAP_STROBES        = 3'h2;
	localparam logic [2:0] SLEEP_STROBES      = 3'h4;
	localparam logic [2:0] STROBE_COUNT_RESET = 3'h0;

	// Result buffer
	localparam int BUFFER_DEPTH = 2;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_LIGHT  = 2'b01,
		PWR_DEEP   = 2'b10
	} power_e;

	localparam power_e POWER_RESET = PWR_ACTIVE;

endpackage : adc_pkg

// ### shared/pair_stream_if.sv
// Valid/ready carrier for result pairs between sampler, buffer and shifter
`timescale 1ns/1ps
interface pair_stream_if;
	import adc_pkg::*;

	logic                 pushValid;
	logic                 pushReady;
	logic [PAIR_BITS-1:0] pushData;
	logic                 popValid;
	logic                 popReady;
	logic [PAIR_BITS-1:0] popData;

	modport store (
		input  pushValid,
		input  pushData,
		input  popReady,
		output pushReady,
		output popValid,
		output popData
	);

	modport user (
		output pushValid,
		output pushData,
		output popReady,
		input  pushReady,
		input  popValid,
		input  popData
	);

endinterface : pair_stream_if

// ### design/pair_buffer.sv
// Two-entry result buffer with honest full and empty
`timescale 1ns/1ps
module pair_buffer
	import adc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Stream
	pair_stream_if.store    stream
);

	logic [PAIR_BITS-1:0] entries      [BUFFER_DEPTH];
	logic [PAIR_BITS-1:0] next_entries [BUFFER_DEPTH];
	logic                 writePtr;
	logic                 next_writePtr;
	logic                 readPtr;
	logic                 next_readPtr;
	logic [1:0]           fill;
	logic [1:0]           next_fill;
	logic                 doPush;
	logic                 doPop;

	assign stream.pushReady = (fill != 2'h2);
	assign stream.popValid  = (fill != 2'h0);
	assign stream.popData   = entries[readPtr];

	always_comb begin
		doPush        = stream.pushValid && stream.pushReady;
		doPop         = stream.popValid && stream.popReady;
		next_entries  = entries;
		next_writePtr = writePtr;
		next_readPtr  = readPtr;
		next_fill     = fill;
		if (doPush) begin
			next_entries[writePtr] = stream.pushData;
			next_writePtr          = ~writePtr;
		end
		if (doPop) begin
			next_readPtr = ~readPtr;
		end
		if (doPush && !doPop) begin
			next_fill = fill + 2'h1;
		end else if (doPop && !doPush) begin
			next_fill = fill - 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		entries <= next_entries;
		if (rst) begin
			writePtr <= 1'b0;
			readPtr  <= 1'b0;
			fill     <= 2'h0;
		end else begin
			writePtr <= next_writePtr;
			readPtr  <= next_readPtr;
			fill     <= next_fill;
		end
	end

endmodule : pair_buffer

// ### design/converter_power_control.sv
// Conversion control, output coding and power-down sequencing of the dual converter
`timescale 1ns/1ps
module converter_power_control
	import adc_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Serial link from host
	input  wire logic                  serialClock,
	input  wire logic                  conversion_start_strobe,
	// Analog inputs, in span fractions
	input  wire logic [INPUT_BITS-1:0] first_pair_positive_input,
	input  wire logic [INPUT_BITS-1:0] first_pair_negative_input,
	input  wire logic [INPUT_BITS-1:0] second_pair_positive_input,
	input  wire logic [INPUT_BITS-1:0] second_pair_negative_input,
	// Serial data pin
	output logic                       serialDataOut,
	output logic                       serialDataOe_n,
	// Status
	output logic                       referenceOn,
	output logic                       lightPowerDown,
	output logic                       deepPowerDown,
	output logic                       conversionBusy
);

	// Signed difference, clamped to the code range
	function automatic logic [RESULT_BITS-1:0] codeOf(
		input logic [INPUT_BITS-1:0] pos,
		input logic [INPUT_BITS-1:0] neg
	);
		logic signed [INPUT_BITS:0] diff;
		diff = signed'({1'b0, pos}) - signed'({1'b0, neg});
		if (diff < 0) begin
			codeOf = CODE_ALL_ZEROS;
		end else if (diff >= SPAN_UNITS) begin
			codeOf = CODE_ALL_ONES;
		end else begin
			codeOf = diff[SPAN_BITS-1 -: RESULT_BITS];
		end
	endfunction : codeOf

	// Two-flop synchronisers; analog codes settle long before a strobe edge matters
	logic                  sckMeta;
	logic                  sckSync;
	logic                  sckPrev;
	logic                  convMeta;
	logic                  convSync;
	logic                  convPrev;
	logic [INPUT_BITS-1:0] anaIn   [4];
	logic [INPUT_BITS-1:0] anaMeta [4];
	logic [INPUT_BITS-1:0] anaSync [4];

	assign anaIn[0] = first_pair_positive_input;
	assign anaIn[1] = first_pair_negative_input;
	assign anaIn[2] = second_pair_positive_input;
	assign anaIn[3] = second_pair_negative_input;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : gAnaSync
			always_ff @(posedge clk) begin
				anaMeta[gi] <= anaIn[gi];
				anaSync[gi] <= anaMeta[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			sckMeta  <= 1'b0;
			sckSync  <= 1'b0;
			sckPrev  <= 1'b0;
			convMeta <= 1'b0;
			convSync <= 1'b0;
			convPrev <= 1'b0;
		end else begin
			sckMeta  <= serialClock;
			sckSync  <= sckMeta;
			sckPrev  <= sckSync;
			convMeta <= conversion_start_strobe;
			convSync <= convMeta;
			convPrev <= convSync;
		end
	end

	logic sckRise;
	logic convRise;

	assign sckRise  = sckSync && !sckPrev;
	assign convRise = convSync && !convPrev;

	// Result buffer between sampler and shifter
	pair_stream_if stream ();

	pair_buffer resultBuffer (
		.clk    (clk),
		.rst    (rst),
		.stream (stream.store)
	);

	// Control state
	power_e               power;
	power_e               next_power;
	logic [2:0]           strobeCount;
	logic [2:0]           next_strobeCount;
	logic                 framing;
	logic                 next_framing;
	logic [5:0]           edgeCount;
	logic [5:0]           next_edgeCount;
	logic [PAIR_BITS-1:0] sampleHeld;
	logic [PAIR_BITS-1:0] next_sampleHeld;
	logic                 sampleWaiting;
	logic                 next_sampleWaiting;
	logic [PAIR_BITS-1:0] shiftReg;
	logic [PAIR_BITS-1:0] next_shiftReg;
	logic                 next_serialDataOut;
	logic                 next_serialDataOe_n;
	logic                 busy;
	logic                 popNow;
	logic [5:0]           edgeNum;

	assign stream.pushValid = sampleWaiting;
	assign stream.pushData  = sampleHeld;
	assign stream.popReady  = popNow;

	always_comb begin
		next_power          = power;
		next_strobeCount    = strobeCount;
		next_framing        = framing;
		next_edgeCount      = edgeCount;
		next_sampleHeld     = sampleHeld;
		next_sampleWaiting  = sampleWaiting;
		next_shiftReg       = shiftReg;
		next_serialDataOut  = serialDataOut;
		next_serialDataOe_n = serialDataOe_n;
		popNow              = 1'b0;
		edgeNum             = edgeCount + 6'h01;
		busy                = framing && (edgeCount < FRAME_EDGES);

		// Sample leaves for the buffer; waits while the buffer is full
		if (sampleWaiting && stream.pushReady) begin
			next_sampleWaiting = 1'b0;
		end

		// Clock edge clears the strobe run and wakes from light power-down
		if (sckRise) begin
			next_strobeCount = STROBE_COUNT_RESET;
			if (power == PWR_LIGHT) begin
				next_power = PWR_ACTIVE;
			end
		end

		// Serial frame; the frame survives a nap so a woken host still gets its data
		if (sckRise && busy) begin
			next_edgeCount = edgeNum;
			if (edgeNum == FIRST_DATA_EDGE) begin
				popNow              = stream.popValid;
				next_serialDataOut  = stream.popValid && stream.popData[PAIR_BITS-1];
				next_shiftReg       = stream.popData << 1;
				next_serialDataOe_n = 1'b0;
			end else if (edgeNum > FIRST_DATA_EDGE
					&& (edgeNum <= WORD0_LAST_EDGE || edgeNum > GAP_LAST_EDGE)) begin
				next_serialDataOut  = shiftReg[PAIR_BITS-1];
				next_shiftReg       = shiftReg << 1;
				next_serialDataOe_n = 1'b0;
			end else if (edgeNum > WORD0_LAST_EDGE) begin
				next_serialDataOe_n = 1'b1;
			end
		end else if (sckRise && framing) begin
			next_framing        = 1'b0;
			next_serialDataOe_n = 1'b1;
		end

		// Strobe: start a conversion, or count towards power-down
		if (convRise) begin
			if (next_strobeCount < SLEEP_STROBES) begin
				next_strobeCount = next_strobeCount + 3'h1;
			end
			if (next_power == PWR_ACTIVE && !busy && next_strobeCount == 3'h1) begin
				next_framing        = 1'b1;
				next_edgeCount      = EDGE_COUNT_RESET;
				next_serialDataOe_n = 1'b1;
				next_sampleWaiting  = 1'b1;
				next_sampleHeld     = {codeOf(anaSync[0], anaSync[1]),
					codeOf(anaSync[2], anaSync[3])};
			end
			if (next_strobeCount == NAP_STROBES) begin
				next_power = PWR_LIGHT;
			end else if (next_strobeCount == SLEEP_STROBES) begin
				next_power = PWR_DEEP;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			power          <= POWER_RESET;
			strobeCount    <= STROBE_COUNT_RESET;
			framing        <= 1'b0;
			edgeCount      <= EDGE_COUNT_RESET;
			sampleHeld     <= '0;
			sampleWaiting  <= 1'b0;
			shiftReg       <= '0;
			serialDataOut  <= 1'b0;
			serialDataOe_n <= 1'b1;
			referenceOn    <= 1'b1;
			lightPowerDown <= 1'b0;
			deepPowerDown  <= 1'b0;
			conversionBusy <= 1'b0;
		end else begin
			power          <= next_power;
			strobeCount    <= next_strobeCount;
			framing        <= next_framing;
			edgeCount      <= next_edgeCount;
			sampleHeld     <= next_sampleHeld;
			sampleWaiting  <= next_sampleWaiting;
			shiftReg       <= next_shiftReg;
			serialDataOut  <= next_serialDataOut;
			serialDataOe_n <= next_serialDataOe_n;
			// Reference off only in deep; leaving deep for light restarts it
			referenceOn    <= (next_power != PWR_DEEP);
			lightPowerDown <= (next_power == PWR_LIGHT);
			deepPowerDown  <= (next_power == PWR_DEEP);
			conversionBusy <= next_framing && (next_edgeCount < FRAME_EDGES);
		end
	end

endmodule : converter_power_control

// ### testbench/converter_power_control_assertions.sv
// Port-level assertions for the converter control, bound to its top
`timescale 1ns/1ps
module converter_power_checker
	import adc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link and status
	input wire logic serialClock,
	input wire logic conversion_start_strobe,
	input wire logic serialDataOe_n,
	input wire logic referenceOn,
	input wire logic lightPowerDown,
	input wire logic deepPowerDown,
	input wire logic conversionBusy
);
	logic [2:0] sckSync;
	logic [2:0] strbSync;
	logic       busyQ;
	logic       strbSeen;
	logic [5:0] edges;
	logic       sckRise;
	logic       strbRise;
	// Own synchroniser, same depth as the design's, so edges line up
	assign sckRise  = sckSync[1] & ~sckSync[2];
	assign strbRise = strbSync[1] & ~strbSync[2];
	always_ff @(posedge clk) begin
		sckSync  <= {sckSync[1:0], serialClock};
		strbSync <= {strbSync[1:0], conversion_start_strobe};
		busyQ    <= conversionBusy;
		strbSeen <= rst || sckRise ? 1'b0 : strbSeen | strbRise;
		if (rst || (conversionBusy && !busyQ))
			edges <= 6'h00;
		else if (sckRise && edges != 6'h3F)
			edges <= edges + 6'h01;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_light_ref: assert property (lightPowerDown |-> referenceOn)
		else $error("reference off in light power-down");
	a_deep_ref: assert property (referenceOn == !deepPowerDown)
		else $error("reference disagrees with deep power-down");
	a_light_wake: assert property (sckRise && lightPowerDown |-> ##[1:4] !lightPowerDown)
		else $error("clock edge did not wake from light power-down");
	a_deep_holds: assert property (sckRise && deepPowerDown |-> ##4 deepPowerDown)
		else $error("lone clock edge left deep power-down");
	a_deep_entry: assert property ($rose(deepPowerDown) |-> $past(lightPowerDown))
		else $error("deep power-down entered without passing light");
	a_busy_start: assert property (strbRise && !strbSeen && !conversionBusy && !lightPowerDown
		&& !deepPowerDown |-> ##[1:3] conversionBusy)
		else $error("strobe did not start a conversion");
	a_start_released: assert property ($rose(conversionBusy) |-> serialDataOe_n)
		else $error("data pin driven at conversion start");
	a_first_bit: assert property (sckRise && conversionBusy && edges == 6'h02 |-> ##4 !serialDataOe_n)
		else $error("data not driven from third edge");
	a_word_gap: assert property (sckRise && conversionBusy && edges == 6'h11 |-> ##4 serialDataOe_n)
		else $error("data pin driven in word gap");
	a_frame_end: assert property (sckRise && conversionBusy && edges == 6'h1F |-> ##4 !conversionBusy)
		else $error("busy outlasted 32 clock edges");
	c_light: cover property ($rose(lightPowerDown));
	c_deep: cover property ($rose(deepPowerDown));
	c_frame: cover property (sckRise && conversionBusy && edges == 6'h1F);
endmodule : converter_power_checker

bind converter_power_control converter_power_checker checker_inst (
	.clk(clk),
	.rst(rst),
	.serialClock(serialClock),
	.conversion_start_strobe(conversion_start_strobe),
	.serialDataOe_n(serialDataOe_n),
	.referenceOn(referenceOn),
	.lightPowerDown(lightPowerDown),
	.deepPowerDown(deepPowerDown),
	.conversionBusy(conversionBusy)
);

// ### testbench/host_port_model.sv
// Host serial port model: makes strobe and clock, captures data
`timescale 1ns/1ps
module host_port_model (
	// Clock
	input wire logic  clk,
	// Link
	output logic      serialClock,
	output logic      conversion_start_strobe,
	input wire logic  serialDataOut,
	input wire logic  serialDataOe_n
);
	logic [31:0] bits;
	logic [31:0] rel;
	logic        lastBit = 1'b0;
	logic        sdoLine;
	// Released pin has no pull: show the inverse of the last driven bit
	assign sdoLine = serialDataOe_n ? ~lastBit : serialDataOut;
	initial begin
		serialClock = 1'b0;
		conversion_start_strobe = 1'b0;
	end
	always @(posedge clk) begin
		if (!serialDataOe_n)
			lastBit <= serialDataOut;
	end
	// Eight clock periods wide pulse, clock held still meanwhile
	task automatic strobe();
		repeat (8) @(posedge clk);
		// Toggled rather than set, so the strobe always returns low
		conversion_start_strobe <= ~conversion_start_strobe;
		repeat (8) @(posedge clk);
		conversion_start_strobe <= ~conversion_start_strobe;
	endtask : strobe
	// 200 ns clock, only while a frame is wanted
	task automatic clocks(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			serialClock <= ~serialClock;
			repeat (4) @(posedge clk);
			serialClock <= ~serialClock;
			bits <= {bits[30:0], sdoLine};
			rel <= {rel[30:0], serialDataOe_n};
			repeat (3) @(posedge clk);
		end
	endtask : clocks
endmodule : host_port_model

// ### testbench/dual_adc_serial_power_control_bench.sv
// Self-checking bench for the dual converter control
`timescale 1ns/1ps
module dual_adc_serial_power_control_bench;
	import adc_pkg::*;
	typedef struct {
		logic [INPUT_BITS-1:0]  p0, n0, p1, n1;
		logic [RESULT_BITS-1:0] c0, c1;
	} row_s;
	logic                  clk, rst, sck, strb, sdo, oeN, refOn, light, deep, busy;
	logic [INPUT_BITS-1:0] p0, n0, p1, n1;
	int                    errors, nChecks, cycles;
	row_s                  rows [4];
	// Reference settle after deep power-down, 2 ms at 25 ns
	localparam int REF_SETTLE_CYCLES = 32'h0001_3880;
	converter_power_control converter_power_control_inst (.clk(clk), .rst(rst),
		.serialClock(sck), .conversion_start_strobe(strb),
		.first_pair_positive_input(p0), .first_pair_negative_input(n0),
		.second_pair_positive_input(p1), .second_pair_negative_input(n1),
		.serialDataOut(sdo), .serialDataOe_n(oeN), .referenceOn(refOn),
		.lightPowerDown(light), .deepPowerDown(deep), .conversionBusy(busy));
	host_port_model host_port_model_inst (.clk(clk), .serialClock(sck),
		.conversion_start_strobe(strb), .serialDataOut(sdo), .serialDataOe_n(oeN));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		if (errors == 0 && nChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task automatic frame(input logic [13:0] c0, input logic [13:0] c1);
		host_port_model_inst.strobe();
		host_port_model_inst.clocks(32);
		check(host_port_model_inst.rel, 32'hC000_C000);
		check({4'h0, host_port_model_inst.bits[29:16], host_port_model_inst.bits[13:0]}, {4'h0, c0, c1});
		check(32'(busy), 32'h0000_0000);
		host_port_model_inst.clocks(1);
		check(32'(oeN), 32'h0000_0001);
	endtask : frame
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Run is near 83000 cycles, mostly the reference settle wait
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 32'h0001_5F90) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		rst = 1'b1;
		{p0, n0, p1, n1} = '0;
		{errors, nChecks} = '0;
		rows = '{'{21'h4_0040, 21'h0, 21'h10_0000, 21'h0, 14'h1001, 14'h3FFF},
			'{21'h0, 21'h40, 21'hF_FFFF, 21'h0, 14'h0, 14'h3FFF},
			'{21'h1F_FFFF, 21'hF_FFFF, 21'h8_0100, 21'h80, 14'h3FFF, 14'h2002},
			'{21'h80, 21'h40, 21'h3F, 21'h0, 14'h1, 14'h0}};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(32'({refOn, light, deep, busy, oeN}), 32'h0000_0011);
		foreach (rows[i]) begin
			p0 <= rows[i].p0;
			n0 <= rows[i].n0;
			p1 <= rows[i].p1;
			n1 <= rows[i].n1;
			frame(rows[i].c0, rows[i].c1);
		end
		// Strobe inside a frame must not restart it
		host_port_model_inst.strobe();
		host_port_model_inst.clocks(10);
		host_port_model_inst.strobe();
		host_port_model_inst.clocks(22);
		check(32'(busy), 32'h0000_0000);
		host_port_model_inst.clocks(1);
		host_port_model_inst.strobe();
		host_port_model_inst.strobe();
		check(32'({light, deep, refOn}), 32'h0000_0005);
		host_port_model_inst.clocks(1);
		check(32'(light), 32'h0000_0000);
		host_port_model_inst.clocks(31);
		repeat (4) host_port_model_inst.strobe();
		check(32'({light, deep, refOn}), 32'h0000_0002);
		host_port_model_inst.clocks(1);
		check(32'(deep), 32'h0000_0001);
		host_port_model_inst.strobe();
		host_port_model_inst.strobe();
		check(32'({light, deep, refOn}), 32'h0000_0005);
		host_port_model_inst.clocks(1);
		check(32'(light), 32'h0000_0000);
		host_port_model_inst.clocks(31);
		// Accurate results only once the reference has settled again
		repeat (REF_SETTLE_CYCLES) @(posedge clk);
		frame(rows[3].c0, rows[3].c1);
		// Reset in mid-run, from deep power-down with a frame pending
		repeat (4) host_port_model_inst.strobe();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(32'({refOn, light, deep, busy, oeN}), 32'h0000_0011);
		frame(rows[3].c0, rows[3].c1);
		wrap_up();
	end
endmodule : dual_adc_serial_power_control_bench
